// file: port0_strap_pkg.sv
// Shared types, offsets, field positions and reset values for the port 0 strap defaults.
package port0_strap_pkg;

  typedef enum logic [1:0] {
    MODE_MII_MAC  = 2'b00,
    MODE_MII_PHY  = 2'b01,
    MODE_RMII_PHY = 2'b10,
    MODE_RESERVED = 2'b11
  } port0_mode_t;

  typedef struct packed {
    logic duplexPol;
    logic backpressure;
    logic fullDuplexFlow;
    logic manualFlow;
    logic heartbeatDisable;
  } soft_straps_t;

  // Strap defaults: backpressure and full-duplex flow control on, the rest off.
  localparam soft_straps_t STRAPS_RESET = 5'h0C;
  localparam int           PIN_WIDTH    = 8;
  localparam logic [PIN_WIDTH-1:0] PINS_RESET = 8'h00;

  localparam logic [7:0] OFS_FLOW    = 8'h00;
  localparam logic [7:0] OFS_PARTNER = 8'h04;
  localparam logic [7:0] OFS_ADVERT  = 8'h08;
  localparam logic [7:0] OFS_SPECIAL = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;

  localparam int FLOW_BP_BIT     = 0;
  localparam int FLOW_RX_BIT     = 1;
  localparam int FLOW_TX_BIT     = 2;
  localparam int FLOW_MANUAL_BIT = 3;
  localparam int AB_10HD_BIT     = 5;
  localparam int AB_10FD_BIT     = 6;
  localparam int AB_100HD_BIT    = 7;
  localparam int AB_100FD_BIT    = 8;
  localparam int AB_PAUSE_BIT    = 10;
  localparam int AB_ASYM_BIT     = 11;
  localparam int SPECIAL_HB_BIT  = 0;

  localparam logic [31:0] FLOW_WMASK    = 32'h0000_000F;
  localparam logic [31:0] PARTNER_WMASK = 32'h0000_0DE0;
  localparam logic [31:0] ADVERT_WMASK  = 32'h0000_0C00;
  localparam logic [31:0] SPECIAL_WMASK = 32'h0000_0001;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE    = 3'b000,
    SEL_FLOW    = 3'b001,
    SEL_PARTNER = 3'b010,
    SEL_ADVERT  = 3'b011,
    SEL_SPECIAL = 3'b100,
    SEL_STATUS  = 3'b101
  } reg_sel_t;

  function automatic reg_sel_t reg_select(input logic [31:0] addr);
    reg_sel_t s;
    s = SEL_NONE;
    if (addr[31:8] == 24'h00_0000) begin
      unique case (addr[7:0])
        OFS_FLOW:    s = SEL_FLOW;
        OFS_PARTNER: s = SEL_PARTNER;
        OFS_ADVERT:  s = SEL_ADVERT;
        OFS_SPECIAL: s = SEL_SPECIAL;
        OFS_STATUS:  s = SEL_STATUS;
        default:     s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : reg_select

  function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [31:0] mask);
    return (old & ~mask) | (wd & mask);
  endfunction : merge_write

endpackage : port0_strap_pkg

// file: port0_pin_sync.sv
// Two-stage synchroniser for the strap and duplex pins.
module port0_pin_sync
  import port0_strap_pkg::*;
(
  // Clock.
  input  wire logic                 clock,
  // Pins and synchronised copy.
  input  wire logic [PIN_WIDTH-1:0] pinsIn,
  output logic      [PIN_WIDTH-1:0] pinsOut
);

  typedef struct packed {
    logic [PIN_WIDTH-1:0] stage1;
    logic [PIN_WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = pinsIn;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  assign pinsOut = state_reg.stage2;

endmodule : port0_pin_sync

// file: port0_strap_latch.sv
// Latches the straps after reset release and takes loader overrides.
module port0_strap_latch
  import port0_strap_pkg::*;
(
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         srst,
  // Synchronised pins.
  input  soft_straps_t      pinStraps,
  input  wire logic [1:0]   pinMode,
  // Loader override.
  input  wire logic         eepromStrapLoad,
  input  soft_straps_t      eepromStraps,
  // Latched values.
  output soft_straps_t      straps,
  output port0_mode_t       mode,
  output logic              applyDefaults,
  output logic              strapsValid
);

  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b00,
    ST_RUN     = 2'b01
  } latch_st_t;

  typedef struct packed {
    latch_st_t    st;
    soft_straps_t straps;
    port0_mode_t  mode;
    logic         apply;
    logic         valid;
  } latch_state_t;

  latch_state_t state_reg;
  latch_state_t state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.apply = 1'h0;
    unique case (state_reg.st)
      ST_CAPTURE: begin
        state_next.straps = pinStraps;
        state_next.mode   = port0_mode_t'(pinMode);
        state_next.apply  = 1'h1;
        state_next.valid  = 1'h1;
        state_next.st     = ST_RUN;
      end
      ST_RUN: begin
        // [R11] Loader replaces soft straps.
        if (eepromStrapLoad) begin
          state_next.straps = eepromStraps;
          state_next.apply  = 1'h1;
        end
      end
      default: begin
        state_next.st = ST_CAPTURE;
      end
    endcase
    if (srst) begin
      state_next.st     = ST_CAPTURE;
      state_next.straps = STRAPS_RESET;
      state_next.mode   = MODE_MII_MAC;
      state_next.apply  = 1'h0;
      state_next.valid  = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  assign straps        = state_reg.straps;
  assign mode          = state_reg.mode;
  assign applyDefaults = state_reg.apply;
  assign strapsValid   = state_reg.valid;

endmodule : port0_strap_latch

// file: port0_soft_strap_defaults.sv
// Port 0 soft strap defaults with an AHB-Lite register slave.
// Overview of operation
// [R1] MAC mode duplex pin uses polarity strap.
// [R2] Polarity strap sets partner duplex ability defaults.
// [R3] Backpressure enable default from its strap.
// [R4] Transmit and receive pause defaults from strap.
// [R5] Full-duplex strap sets partner pause defaults.
// [R6] Manual select default from manual strap.
// [R7] Manual strap sets advertised pause defaults.
// [R8] MAC mode ignores manual strap; host decides.
// [R9] MII PHY mode: heartbeat-off from strap.
// [R10] Heartbeat strap ignored in RMII, MAC modes.
// [R11] Loader may replace latched soft straps.
// [R12] Straps give defaults only; writes work.
//
// Chosen here: the address map and the AHB-Lite register port.
module port0_soft_strap_defaults
  import port0_strap_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        srst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Strap and duplex pins.
  input  wire logic        port0DuplexIndication,
  input  wire logic        strapDuplexPolarity,
  input  wire logic        port0BackpressureDefaultStrap,
  input  wire logic        port0FullduplexFlowStrap,
  input  wire logic        port0ManualFlowStrap,
  input  wire logic        heartbeatDisableStrap,
  input  wire logic [1:0]  port0ModeStrap,
  // Loader override.
  input  wire logic        eepromStrapLoad,
  input  soft_straps_t     eepromStraps,
  // Configuration outputs.
  output logic             port0FullDuplex,
  output logic             port0BackpressureEnable,
  output logic             port0TransmitPauseEnable,
  output logic             port0ReceivePauseEnable,
  output logic             port0ManualFlowSelect,
  output logic             heartbeatOff,
  output logic             defaultsValid
);

  typedef struct packed {
    logic [31:0] flowReg;
    logic [31:0] partnerReg;
    logic [31:0] advertReg;
    logic [31:0] specialReg;
    logic        dataPhase;
    logic        dataWrite;
    reg_sel_t    dataSel;
    logic [31:0] rdata;
    logic        fullDuplex;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  logic [PIN_WIDTH-1:0] rawPins;
  logic [PIN_WIDTH-1:0] syncPins;
  soft_straps_t         pinStraps;
  logic                 syncDuplex;
  soft_straps_t         straps;
  port0_mode_t          mode;
  logic                 applyDefaults;
  logic                 strapsValid;
  logic                 macMode;
  logic [31:0]          flowDefault;
  logic [31:0]          partnerDefault;
  logic [31:0]          advertDefault;
  logic [31:0]          specialDefault;
  logic                 accept;
  reg_sel_t             addrSel;
  logic [31:0]          readWord;

  assign rawPins = {port0DuplexIndication, port0ModeStrap, strapDuplexPolarity,
                    port0BackpressureDefaultStrap, port0FullduplexFlowStrap,
                    port0ManualFlowStrap, heartbeatDisableStrap};

  // Every pin is asynchronous, so all of them pass the two-flop synchroniser.
  port0_pin_sync u_pin_sync (
    .clock   (clock),
    .pinsIn  (rawPins),
    .pinsOut (syncPins)
  );

  assign pinStraps  = soft_straps_t'(syncPins[4:0]);
  assign syncDuplex = syncPins[7];

  port0_strap_latch u_strap_latch (
    .clock           (clock),
    .srst            (srst),
    .pinStraps       (pinStraps),
    .pinMode         (syncPins[6:5]),
    .eepromStrapLoad (eepromStrapLoad),
    .eepromStraps    (eepromStraps),
    .straps          (straps),
    .mode            (mode),
    .applyDefaults   (applyDefaults),
    .strapsValid     (strapsValid)
  );

  assign macMode = (mode == MODE_MII_MAC);

  always_comb begin
    flowDefault    = REG_RESET;
    partnerDefault = REG_RESET;
    advertDefault  = REG_RESET;
    specialDefault = REG_RESET;
    // [R3] Backpressure enable default.
    flowDefault[FLOW_BP_BIT] = straps.backpressure;
    // [R4] Both pause enables from strap.
    flowDefault[FLOW_RX_BIT] = straps.fullDuplexFlow;
    flowDefault[FLOW_TX_BIT] = straps.fullDuplexFlow;
    // [R6] [R8] Manual select, ignored in MAC.
    flowDefault[FLOW_MANUAL_BIT] = straps.manualFlow & ~macMode;
    // [R2] Polarity strap shapes duplex abilities.
    partnerDefault[AB_100FD_BIT] = ~straps.duplexPol;
    partnerDefault[AB_10FD_BIT]  = ~straps.duplexPol;
    partnerDefault[AB_100HD_BIT] = 1'h1;
    partnerDefault[AB_10HD_BIT]  = 1'h1;
    // [R5] Partner pause bits from strap.
    partnerDefault[AB_PAUSE_BIT] = straps.fullDuplexFlow;
    partnerDefault[AB_ASYM_BIT]  = straps.fullDuplexFlow;
    // [R7] [R8] Advertised pause from manual strap.
    advertDefault[AB_PAUSE_BIT] = ~straps.manualFlow & ~macMode;
    advertDefault[AB_ASYM_BIT]  = ~straps.manualFlow & ~macMode;
    // [R9] [R10] Heartbeat-off only in MII PHY mode.
    specialDefault[SPECIAL_HB_BIT] = straps.heartbeatDisable & (mode == MODE_MII_PHY);
  end

  assign accept  = hsel & htrans[1] & hready;
  assign addrSel = reg_select(haddr);

  always_comb begin
    state_next = state_reg;
    // [R1] Duplex pin polarity in MAC mode.
    state_next.fullDuplex = macMode & (syncDuplex ^ straps.duplexPol);
    // [R12] Software writes after the defaults.
    if (state_reg.dataPhase && state_reg.dataWrite) begin
      unique case (state_reg.dataSel)
        SEL_FLOW:    state_next.flowReg    = merge_write(state_reg.flowReg, hwdata, FLOW_WMASK);
        SEL_PARTNER: state_next.partnerReg = merge_write(state_reg.partnerReg, hwdata, PARTNER_WMASK);
        SEL_ADVERT:  state_next.advertReg  = merge_write(state_reg.advertReg, hwdata, ADVERT_WMASK);
        SEL_SPECIAL: state_next.specialReg = merge_write(state_reg.specialReg, hwdata, SPECIAL_WMASK);
        default: begin
        end
      endcase
    end
    // [R11] Reload defaults when straps are replaced.
    // The reload follows the write, so it wins when both fall in one cycle.
    if (applyDefaults) begin
      state_next.flowReg    = flowDefault;
      state_next.partnerReg = partnerDefault;
      state_next.advertReg  = advertDefault;
      state_next.specialReg = specialDefault;
    end
    // Reads return the next state, so a read right after a write sees it.
    readWord = 32'h0000_0000;
    unique case (addrSel)
      SEL_FLOW:    readWord = state_next.flowReg;
      SEL_PARTNER: readWord = state_next.partnerReg;
      SEL_ADVERT:  readWord = state_next.advertReg;
      SEL_SPECIAL: readWord = state_next.specialReg;
      SEL_STATUS:  readWord = {23'h00_0000, strapsValid, state_next.fullDuplex, mode, straps};
      SEL_NONE:    readWord = 32'h0000_0000;
    endcase
    if (hready) begin
      state_next.dataPhase = accept;
      state_next.dataWrite = accept & hwrite;
      state_next.dataSel   = accept ? addrSel : SEL_NONE;
      if (accept && !hwrite) begin
        state_next.rdata = readWord;
      end
    end
    if (srst) begin
      state_next.flowReg    = REG_RESET;
      state_next.partnerReg = REG_RESET;
      state_next.advertReg  = REG_RESET;
      state_next.specialReg = REG_RESET;
      state_next.dataPhase  = 1'h0;
      state_next.dataWrite  = 1'h0;
      state_next.dataSel    = SEL_NONE;
      state_next.rdata      = REG_RESET;
      state_next.fullDuplex = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  // The slave never inserts wait states and always answers OKAY.
  assign hreadyout                = 1'h1;
  assign hresp                    = 1'h0;
  assign hrdata                   = state_reg.rdata;
  assign port0FullDuplex          = state_reg.fullDuplex;
  assign port0BackpressureEnable  = state_reg.flowReg[FLOW_BP_BIT];
  assign port0TransmitPauseEnable = state_reg.flowReg[FLOW_TX_BIT];
  assign port0ReceivePauseEnable  = state_reg.flowReg[FLOW_RX_BIT];
  assign port0ManualFlowSelect    = state_reg.flowReg[FLOW_MANUAL_BIT];
  assign heartbeatOff             = state_reg.specialReg[SPECIAL_HB_BIT];
  assign defaultsValid            = strapsValid;

  // All checks run on the one clock and pause while reset is held.
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_duplex_polarity: assert property ( // [R1]
    macMode && $past(macMode) |=> port0FullDuplex == $past(syncDuplex ^ straps.duplexPol))
    else $error("Duplex indication polarity wrong.");

  a_partner_duplex: assert property ( // [R2]
    applyDefaults |=> state_reg.partnerReg[AB_100FD_BIT] == ~$past(straps.duplexPol)
                      && state_reg.partnerReg[AB_10FD_BIT] == ~$past(straps.duplexPol))
    else $error("Partner duplex ability default wrong.");

  a_backpressure_load: assert property ( // [R3]
    applyDefaults |=> port0BackpressureEnable == $past(straps.backpressure))
    else $error("Backpressure default not loaded.");

  a_pause_enables: assert property ( // [R4]
    applyDefaults |=> port0TransmitPauseEnable == $past(straps.fullDuplexFlow)
                      && port0ReceivePauseEnable == $past(straps.fullDuplexFlow))
    else $error("Pause enable defaults wrong.");

  a_partner_pause: assert property ( // [R5]
    applyDefaults |=> state_reg.partnerReg[AB_ASYM_BIT:AB_PAUSE_BIT] == {2{$past(straps.fullDuplexFlow)}})
    else $error("Partner pause defaults wrong.");

  a_manual_select: assert property ( // [R6]
    applyDefaults && !macMode |=> port0ManualFlowSelect == $past(straps.manualFlow))
    else $error("Manual flow select default wrong.");

  a_advert_pause: assert property ( // [R7]
    applyDefaults && !macMode |=> state_reg.advertReg[AB_ASYM_BIT:AB_PAUSE_BIT] == {2{~$past(straps.manualFlow)}})
    else $error("Advertised pause defaults wrong.");

  a_mac_ignores: assert property ( // [R8]
    applyDefaults && macMode |=> !port0ManualFlowSelect && state_reg.advertReg[AB_ASYM_BIT:AB_PAUSE_BIT] == 2'h0)
    else $error("Manual strap used in MAC mode.");

  a_heartbeat_phy: assert property ( // [R9]
    applyDefaults && mode == MODE_MII_PHY |=> heartbeatOff == $past(straps.heartbeatDisable))
    else $error("Heartbeat-off default wrong in MII PHY mode.");

  a_heartbeat_other: assert property ( // [R10]
    applyDefaults && mode != MODE_MII_PHY |=> !heartbeatOff)
    else $error("Heartbeat strap used outside MII PHY mode.");

  a_eeprom_override: assert property ( // [R11]
    eepromStrapLoad && strapsValid |-> ##2 port0BackpressureEnable == $past(eepromStraps.backpressure, 2))
    else $error("Loader override not applied.");

  a_software_write: assert property ( // [R12]
    state_reg.dataPhase && state_reg.dataWrite && state_reg.dataSel == SEL_FLOW && !applyDefaults
    |=> state_reg.flowReg[3:0] == $past(hwdata[3:0]))
    else $error("Software write to flow register lost.");

  a_fullduplex_phy: assert property ( // [R1]
    !macMode |=> !port0FullDuplex)
    else $error("Full duplex shown outside MAC mode.");

  a_partner_half: assert property ( // [R2]
    applyDefaults |=> state_reg.partnerReg[AB_100HD_BIT] && state_reg.partnerReg[AB_10HD_BIT])
    else $error("Partner half duplex ability default wrong.");

  a_advert_mask: assert property ( // [R7]
    (state_reg.advertReg & ~ADVERT_WMASK) == REG_RESET)
    else $error("Advertisement bit set outside its field.");

  a_special_read: assert property ( // [R9]
    accept && !hwrite && addrSel == SEL_SPECIAL |=> hrdata == state_reg.specialReg)
    else $error("Special register read data wrong.");

  a_mode_held: assert property ( // [R11]
    strapsValid |=> $stable(mode))
    else $error("Port mode changed after it was latched.");

  a_valid_held: assert property ( // [R11]
    strapsValid |=> strapsValid)
    else $error("Defaults valid dropped without reset.");

  a_status_read: assert property ( // [R11]
    accept && !hwrite && addrSel == SEL_STATUS |=> hrdata[4:0] == $past(straps))
    else $error("Status read shows wrong straps.");

  a_flow_mask: assert property ( // [R12]
    (state_reg.flowReg & ~FLOW_WMASK) == REG_RESET)
    else $error("Flow register bit set outside its field.");

  a_flow_read: assert property ( // [R12]
    accept && !hwrite && addrSel == SEL_FLOW |=> hrdata == state_reg.flowReg)
    else $error("Flow register read data wrong.");

  a_bus_okay: assert property ( // [R12]
    hreadyout && !hresp)
    else $error("Slave stalled or answered with an error.");

endmodule : port0_soft_strap_defaults

// file: tb_port0_soft_strap_defaults.sv
// Self-checking testbench for the port 0 soft strap defaults block.
module tb_top
  import port0_strap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic         clock;
  logic         srst;
  logic         hsel;
  logic         hwrite;
  logic         eepromStrapLoad;
  logic         dupPin;
  logic  [31:0] haddr;
  logic  [31:0] hwdata;
  logic  [1:0]  htrans;
  logic  [1:0]  modePin;
  logic  [2:0]  hsize;
  soft_straps_t pinS;
  soft_straps_t eepromStraps;
  wire logic        hreadyout;
  wire logic        hresp;
  wire logic [31:0] hrdata;
  wire logic        port0FullDuplex;
  wire logic        port0BackpressureEnable;
  wire logic        port0TransmitPauseEnable;
  wire logic        port0ReceivePauseEnable;
  wire logic        port0ManualFlowSelect;
  wire logic        heartbeatOff;
  wire logic        defaultsValid;
  int           errTotal;
  int           checkCount;
  int           cycles;
  int           seed;

  port0_soft_strap_defaults dut (
    .clock                         (clock),
    .srst                          (srst),
    .hsel                          (hsel),
    .haddr                         (haddr),
    .htrans                        (htrans),
    .hwrite                        (hwrite),
    .hsize                         (hsize),
    .hwdata                        (hwdata),
    .hready                        (hreadyout),
    .hreadyout                     (hreadyout),
    .hresp                         (hresp),
    .hrdata                        (hrdata),
    .port0DuplexIndication         (dupPin),
    .strapDuplexPolarity           (pinS.duplexPol),
    .port0BackpressureDefaultStrap (pinS.backpressure),
    .port0FullduplexFlowStrap      (pinS.fullDuplexFlow),
    .port0ManualFlowStrap          (pinS.manualFlow),
    .heartbeatDisableStrap         (pinS.heartbeatDisable),
    .port0ModeStrap                (modePin),
    .eepromStrapLoad               (eepromStrapLoad),
    .eepromStraps                  (eepromStraps),
    .port0FullDuplex               (port0FullDuplex),
    .port0BackpressureEnable       (port0BackpressureEnable),
    .port0TransmitPauseEnable      (port0TransmitPauseEnable),
    .port0ReceivePauseEnable       (port0ReceivePauseEnable),
    .port0ManualFlowSelect         (port0ManualFlowSelect),
    .heartbeatOff                  (heartbeatOff),
    .defaultsValid                 (defaultsValid)
  );

  always #20 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errTotal++;
      finalReport();
    end
  end

  function automatic logic [31:0] expFlow(input soft_straps_t s, input port0_mode_t m);
    return {28'h000_0000, s.manualFlow & (m != MODE_MII_MAC), s.fullDuplexFlow, s.fullDuplexFlow, s.backpressure};
  endfunction : expFlow

  function automatic logic [31:0] expPartner(input soft_straps_t s);
    return {20'h0_0000, s.fullDuplexFlow, s.fullDuplexFlow, 1'b0, ~s.duplexPol, 1'b1, ~s.duplexPol, 1'b1, 5'h00};
  endfunction : expPartner

  function automatic logic [31:0] expAdvert(input soft_straps_t s, input port0_mode_t m);
    return {20'h0_0000, {2{~s.manualFlow & (m != MODE_MII_MAC)}}, 10'h000};
  endfunction : expAdvert

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      errTotal++;
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      errTotal++;
    end
  endtask : chk1

  task automatic ahbXfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahbXfer

  task automatic doReset(input soft_straps_t s, input port0_mode_t m);
    @(posedge clock);
    srst    <= 1'b1;
    pinS    <= s;
    modePin <= m;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : doReset

  task automatic checkState(input soft_straps_t s, input port0_mode_t m);
    logic [31:0] rd;
    logic        fd;
    fd = (m == MODE_MII_MAC) ? (dupPin ^ s.duplexPol) : 1'b0;
    ahbXfer(1'b0, {24'h00_0000, OFS_FLOW}, 32'h0000_0000, rd);
    chk32(rd, expFlow(s, m));
    ahbXfer(1'b0, {24'h00_0000, OFS_PARTNER}, 32'h0000_0000, rd);
    chk32(rd, expPartner(s));
    ahbXfer(1'b0, {24'h00_0000, OFS_ADVERT}, 32'h0000_0000, rd);
    chk32(rd, expAdvert(s, m));
    ahbXfer(1'b0, {24'h00_0000, OFS_SPECIAL}, 32'h0000_0000, rd);
    chk32(rd, {31'h0, s.heartbeatDisable & (m == MODE_MII_PHY)});
    ahbXfer(1'b0, {24'h00_0000, OFS_STATUS}, 32'h0000_0000, rd);
    chk32(rd, {23'h0, 1'b1, fd, m, s});
    chk1(port0FullDuplex, fd);
    chk1(port0BackpressureEnable, s.backpressure);
    chk1(port0TransmitPauseEnable, s.fullDuplexFlow);
    chk1(port0ReceivePauseEnable, s.fullDuplexFlow);
    chk1(port0ManualFlowSelect, s.manualFlow & (m != MODE_MII_MAC));
    chk1(heartbeatOff, s.heartbeatDisable & (m == MODE_MII_PHY));
    chk1(defaultsValid, 1'b1);
  endtask : checkState

  task finalReport;
    if (errTotal == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finalReport

  initial begin
    logic [31:0]  rd;
    logic [31:0]  d;
    logic [31:0]  dFlow;
    logic [31:0]  dSpec;
    logic [7:0]   offs  [4];
    logic [31:0]  masks [4];
    soft_straps_t s;
    soft_straps_t s2;
    port0_mode_t  m;
    offs  = '{OFS_FLOW, OFS_PARTNER, OFS_ADVERT, OFS_SPECIAL};
    masks = '{FLOW_WMASK, PARTNER_WMASK, ADVERT_WMASK, SPECIAL_WMASK};
    seed            = 83;
    clock           = 1'b0;
    srst            = 1'b1;
    hsel            = 1'b0;
    haddr           = 32'h0000_0000;
    htrans          = 2'h0;
    hwrite          = 1'b0;
    hsize           = 3'h2;
    hwdata          = 32'h0000_0000;
    pinS            = STRAPS_RESET;
    modePin         = 2'h0;
    dupPin          = 1'b0;
    eepromStrapLoad = 1'b0;
    eepromStraps    = STRAPS_RESET;
    errTotal        = 0;
    checkCount      = 0;
    cycles          = 0;
    dFlow           = 32'h0000_0000;
    dSpec           = 32'h0000_0000;
    for (int i = 0; i < 9; i++) begin
      s      = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : (i == 2) ? STRAPS_RESET : soft_straps_t'(5'($random(seed)));
      m      = port0_mode_t'(i % 3);
      dupPin <= 1'($random(seed));
      doReset(s, m);
      checkState(s, m);
      if (m == MODE_MII_MAC) begin
        @(posedge clock);
        dupPin <= ~dupPin;
        repeat (5) @(posedge clock);
        chk1(port0FullDuplex, dupPin ^ s.duplexPol);
      end
      for (int k = 0; k < 4; k++) begin
        d = $random(seed);
        ahbXfer(1'b1, {24'h00_0000, offs[k]}, d, rd);
        ahbXfer(1'b0, {24'h00_0000, offs[k]}, 32'h0000_0000, rd);
        chk32(rd, d & masks[k]);
        if (k == 0) dFlow = d;
        if (k == 3) dSpec = d;
      end
      chk1(port0BackpressureEnable, dFlow[FLOW_BP_BIT]);
      chk1(port0ReceivePauseEnable, dFlow[FLOW_RX_BIT]);
      chk1(port0TransmitPauseEnable, dFlow[FLOW_TX_BIT]);
      chk1(port0ManualFlowSelect, dFlow[FLOW_MANUAL_BIT]);
      chk1(heartbeatOff, dSpec[SPECIAL_HB_BIT]);
      ahbXfer(1'b1, 32'h0000_0014, 32'hFFFF_FFFF, rd);
      ahbXfer(1'b0, 32'h0000_0014, 32'h0000_0000, rd);
      chk32(rd, 32'h0000_0000);
      s2 = soft_straps_t'(5'($random(seed)));
      @(posedge clock);
      eepromStraps    <= s2;
      eepromStrapLoad <= 1'b1;
      @(posedge clock);
      eepromStrapLoad <= 1'b0;
      repeat (4) @(posedge clock);
      checkState(s2, m);
    end
    finalReport();
  end

endmodule : tb_top
